// ---- rtl/dtfs_defines.svh ----
`ifndef DTFS_DEFINES_SVH
`define DTFS_DEFINES_SVH
// ****************************************
// timing figures and derived cycle counts
// ****************************************
`define DTFS_CLK_MHZ        125
`define DTFS_BLANK_US       10
`define DTFS_BLANK_CYC      (`DTFS_BLANK_US * `DTFS_CLK_MHZ)
`define DTFS_DT_MAX_NS      1000
`define DTFS_DT_MAX_CYC     ((`DTFS_DT_MAX_NS * `DTFS_CLK_MHZ) / 1000)
`define DTFS_AREC_MS        1000
`define DTFS_AREC_CYC       (`DTFS_AREC_MS * `DTFS_CLK_MHZ * 1000)
`define DTFS_SKIP_OFF_CYC   2000
`define DTFS_FAULT_CNT_RST  8'h04
// ****************************************
// dead-time option codes
// ****************************************
`define DTFS_OPT_NOFAULT    2'h0
`define DTFS_OPT_LATCH      2'h1
`define DTFS_OPT_AREC       2'h2
`define DTFS_OPT_FIXED      2'h3
`endif

// ---- rtl/dtfs_pkg.sv ----
// ****************************************
// shared types
// ****************************************
package dtfs_pkg;
	typedef enum logic [6:0] {
		DTFS_OFF   = 7'h01,
		DTFS_BLANK = 7'h02,
		DTFS_WAIT  = 7'h04,
		DTFS_RUN   = 7'h08,
		DTFS_AREC  = 7'h10,
		DTFS_LATCH = 7'h20,
		DTFS_THERM = 7'h40
	} dtfs_state_t;
	typedef enum logic [1:0] {
		DTFS_MODE_SYM   = 2'h0,
		DTFS_MODE_LIGHT = 2'h1,
		DTFS_MODE_SKIP  = 2'h2
	} dtfs_mode_t;
endpackage : dtfs_pkg

// ---- rtl/dtfs_down_timer.sv ----
`timescale 1ns/1ps
// ****************************************
// loadable down counter, done is a level
// ****************************************
module dtfs_down_timer #(
	parameter int W = 32
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	input  wire logic         run_in,
	output logic              done_out
);
	logic [W-1:0] cnt_q;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cnt_q <= '0;
		else if (load_in)
			cnt_q <= value_in;
		else if (run_in && cnt_q != '0)
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end
	assign done_out = (cnt_q == '0);
endmodule : dtfs_down_timer

// ---- rtl/dtfs_gap_ctrl.sv ----
`timescale 1ns/1ps
// ****************************************
// dead-time gap between the two switches
// ****************************************
module dtfs_gap_ctrl #(
	parameter int DT_W = 16
) (
	input  wire logic            clk_in,
	input  wire logic            rst_n_in,
	input  wire logic            enable_in,
	input  wire logic            fixed_in,
	input  wire logic [DT_W-1:0] dt_max_in,
	input  wire logic            on_done_in,
	input  wire logic            tr_hl_in,
	input  wire logic            tr_lh_in,
	output logic                 upper_q_out,
	output logic                 lower_q_out,
	output logic                 expiry_out
);
	typedef enum logic [3:0] {
		G_UP = 4'h1, G_GAP_DN = 4'h2, G_LO = 4'h4, G_GAP_UP = 4'h8
	} dtfs_gap_t;
	dtfs_gap_t    st_q;
	logic [DT_W-1:0] gap_q;
	logic         gap_end;
	logic         tr_seen;
	assign tr_seen = (st_q == G_GAP_DN) ? tr_hl_in : tr_lh_in;
	// fixed option never looks at the sensor
	assign gap_end = (!fixed_in && tr_seen) || gap_q >= dt_max_in;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q       <= G_GAP_UP;
			gap_q      <= '0;
			expiry_out <= 1'b0;
		end else begin
			expiry_out <= 1'b0;
			if (!enable_in) begin
				st_q  <= G_GAP_UP;
				gap_q <= '0;
			end else begin
				case (st_q)
				G_UP, G_LO: begin
					gap_q <= '0;
					if (on_done_in)
						st_q <= (st_q == G_UP) ? G_GAP_DN : G_GAP_UP;
				end
				G_GAP_DN, G_GAP_UP: begin
					gap_q <= gap_q + {{(DT_W-1){1'b0}}, 1'b1};
					if (gap_end) begin
						st_q <= (st_q == G_GAP_DN) ? G_LO : G_UP;
						expiry_out <= !fixed_in && !tr_seen;
					end
				end
				default: st_q <= G_GAP_UP;
				endcase
			end
		end
	end
	assign upper_q_out = enable_in && st_q == G_UP;
	assign lower_q_out = enable_in && st_q == G_LO;
endmodule : dtfs_gap_ctrl

// ---- rtl/dtfs_sequencer.sv ----
`timescale 1ns/1ps
`include "dtfs_defines.svh"
// Notes on behaviour
// - full and medium load: both switches get equal halves of the period
// - below light-load level: minimum patterns separated by controlled off-time
// - feedback below skip threshold: quiet skip with bursts and idle gaps
// - skip burst rate regulated around a clamp, may drop at no load
// - opposite switch turns on only after the matching transition flag
// - no transition within maximum dead time forces opposite switch on
// - no-fault option: expiry only forces the switch, no fault
// - latching option: expiry without transition causes latch-off
// - auto-recovery option: expiry stops switching, restarts after recovery delay
// - counter option: fault confirmed after selected number of expiries
// - fixed option: sensor ignored, maximum dead time always, no fault
// - over-temperature stops switching at once, enters stored off state
// - over-temperature clearing performs a full restart with soft-start
// - supply-on enables brown-out, feedback, protection and front-stage blocks
// - supply-on from the off state starts blanking; faults ignored until it ends
// - while a fault persists drivers stay off in self-supply, blocks biased
// - bulk-good starts the startup current source to recharge supply
// - blanking ends with no fault: drivers enabled, application starts
// - bulk-good lost: drivers and protection bias off, front-stage stays high
// - brown-out recovery and new supply-on resume via startup and soft-start
// - protection input latches off: all but feedback disabled, self-supply
// - latch-off clears only when supply falls below its reset level
// - skip idle gaps power down all but feedback and supply management
// - auto-recovery timer counts delay before startup source re-enabled
module dtfs_sequencer #(
	parameter int        DT_W      = 16,
	parameter int        AREC_CYC  = `DTFS_AREC_CYC,
	parameter int        BLANK_CYC = `DTFS_BLANK_CYC,
	parameter int        SKIP_CYC  = `DTFS_SKIP_OFF_CYC,
	parameter int        ON_W      = 12
) (
	input  wire logic            clk_in,
	input  wire logic            arst_n_in,
	input  wire logic            supply_on_threshold_in,
	input  wire logic            supply_clear_threshold_in,
	input  wire logic            bulk_level_good_in,
	input  wire logic            thermal_shutdown_in,
	input  wire logic            overvoltage_overtemp_input_in,
	input  wire logic            fb_light_in,
	input  wire logic            fb_skip_in,
	input  wire logic [1:0]      gap_option_in,
	input  wire logic            gap_count_en_in,
	input  wire logic [7:0]      gap_fault_count_limit_in,
	input  wire logic [ON_W-1:0] on_time_in,
	input  wire logic [ON_W-1:0] light_off_time_in,
	input  wire logic            tr_upper_to_lower_in,
	input  wire logic            tr_lower_to_upper_in,
	output logic                 drv_upper_out,
	output logic                 drv_lower_out,
	output logic                 startup_source_out,
	output logic                 self_supply_mode_out,
	output logic                 bias_bo_out,
	output logic                 bias_fb_out,
	output logic                 bias_prot_out,
	output logic                 front_stage_control_output_out,
	output logic                 soft_start_req_out,
	output logic                 latched_out,
	output logic                 thermal_stored_out,
	output logic [1:0]           load_mode_out
);
	// ****************************************
	// reset release
	// ****************************************
	logic rst_s1_q, rst_n;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// ****************************************
	// state and edge tracking
	// ****************************************
	dtfs_pkg::dtfs_state_t st_q, st_d;
	dtfs_pkg::dtfs_mode_t  mode_q;
	logic vcc_on_prev_q, vcc_on_rise;
	logic therm_q;
	logic blank_done, arec_done, skip_done;
	logic blank_load, arec_load;
	logic up_w, lo_w, expiry;
	logic [7:0] fcnt_q;
	logic dt_fault;
	logic gap_en;
	logic burst_on_q;
	logic [ON_W-1:0] ph_q;
	logic phase_done;
	logic skip_load;

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			vcc_on_prev_q <= 1'b0;
		end else begin
			vcc_on_prev_q <= supply_on_threshold_in;
		end
	end
	assign vcc_on_rise = supply_on_threshold_in && !vcc_on_prev_q;

	// ****************************************
	// timers
	// ****************************************
	assign blank_load = vcc_on_rise;
	assign arec_load  = (st_q != dtfs_pkg::DTFS_AREC)
		&& (st_d == dtfs_pkg::DTFS_AREC);

	dtfs_down_timer #(.W(32)) u_blank (
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.load_in  (blank_load),
		.value_in (BLANK_CYC[31:0]),
		.run_in   (1'b1),
		.done_out (blank_done)
	);
	dtfs_down_timer #(.W(32)) u_arec (
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.load_in  (arec_load),
		.value_in (AREC_CYC[31:0]),
		.run_in   (st_q == dtfs_pkg::DTFS_AREC),
		.done_out (arec_done)
	);
	dtfs_down_timer #(.W(32)) u_skip (
		.clk_in   (clk_in),
		.rst_n_in (rst_n),
		.load_in  (skip_load),
		.value_in ((mode_q == dtfs_pkg::DTFS_MODE_LIGHT)
			? {{(32-ON_W){1'b0}}, light_off_time_in} : SKIP_CYC[31:0]),
		.run_in   (1'b1),
		.done_out (skip_done)
	);

	// ****************************************
	// dead-time fault qualification
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			fcnt_q <= 8'h00;
		else if (st_q != dtfs_pkg::DTFS_RUN)
			fcnt_q <= 8'h00;
		else if (expiry && fcnt_q != 8'hff)
			fcnt_q <= fcnt_q + 8'h01;
	end
	// counter option waits for the limit; otherwise first expiry counts
	assign dt_fault = expiry && gap_option_in != `DTFS_OPT_NOFAULT
		&& gap_option_in != `DTFS_OPT_FIXED
		&& (!gap_count_en_in
			|| (fcnt_q + 8'h01) >= gap_fault_count_limit_in);

	// ****************************************
	// main sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		case (st_q)
		dtfs_pkg::DTFS_OFF:
			if (vcc_on_rise)
				st_d = dtfs_pkg::DTFS_BLANK;
		dtfs_pkg::DTFS_BLANK:
			if (blank_done) begin
				if (bulk_level_good_in && !thermal_shutdown_in
					&& !overvoltage_overtemp_input_in)
					st_d = dtfs_pkg::DTFS_RUN;
				else if (overvoltage_overtemp_input_in)
					st_d = dtfs_pkg::DTFS_LATCH;
				else
					st_d = dtfs_pkg::DTFS_WAIT;
			end
		dtfs_pkg::DTFS_WAIT:
			if (bulk_level_good_in && !thermal_shutdown_in
				&& !overvoltage_overtemp_input_in)
				st_d = dtfs_pkg::DTFS_OFF;
		dtfs_pkg::DTFS_RUN:
			if (thermal_shutdown_in)
				st_d = dtfs_pkg::DTFS_THERM;
			else if (overvoltage_overtemp_input_in)
				st_d = dtfs_pkg::DTFS_LATCH;
			else if (!bulk_level_good_in)
				st_d = dtfs_pkg::DTFS_WAIT;
			else if (dt_fault && gap_option_in == `DTFS_OPT_LATCH)
				st_d = dtfs_pkg::DTFS_LATCH;
			else if (dt_fault && gap_option_in == `DTFS_OPT_AREC)
				st_d = dtfs_pkg::DTFS_AREC;
		dtfs_pkg::DTFS_AREC:
			if (arec_done)
				st_d = dtfs_pkg::DTFS_OFF;
		dtfs_pkg::DTFS_THERM:
			if (!thermal_shutdown_in)
				st_d = dtfs_pkg::DTFS_OFF;
		dtfs_pkg::DTFS_LATCH:
			st_d = dtfs_pkg::DTFS_LATCH;
		default:
			st_d = dtfs_pkg::DTFS_OFF;
		endcase
		// faults during blanking ignored; latch leaves only on supply loss
		if (supply_clear_threshold_in)
			st_d = dtfs_pkg::DTFS_OFF;
	end

	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			st_q <= dtfs_pkg::DTFS_OFF;
		else
			st_q <= st_d;
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			therm_q <= 1'b0;
		else
			therm_q <= (st_d == dtfs_pkg::DTFS_THERM);
	end

	// ****************************************
	// load modes and burst pacing
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			mode_q <= dtfs_pkg::DTFS_MODE_SYM;
		else if (fb_skip_in)
			mode_q <= dtfs_pkg::DTFS_MODE_SKIP;
		else if (fb_light_in)
			mode_q <= dtfs_pkg::DTFS_MODE_LIGHT;
		else
			mode_q <= dtfs_pkg::DTFS_MODE_SYM;
	end

	// equal up and down phases from one on-time count
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			ph_q <= '0;
		else if (up_w || lo_w)
			ph_q <= (ph_q == on_time_in) ? '0 : ph_q + 1'b1;
		else
			ph_q <= '0;
	end
	assign phase_done = (up_w || lo_w) && ph_q == on_time_in;

	// skip: burst rate held by the idle timer clamp; feedback stays low
	// longer at no load so gaps stretch and the rate falls further
	assign skip_load = burst_on_q && lo_w && phase_done
		&& mode_q != dtfs_pkg::DTFS_MODE_SYM;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			burst_on_q <= 1'b1;
		else if (mode_q == dtfs_pkg::DTFS_MODE_SYM)
			burst_on_q <= 1'b1;
		else if (skip_load)
			burst_on_q <= 1'b0;
		else if (!burst_on_q && skip_done
			&& (mode_q == dtfs_pkg::DTFS_MODE_LIGHT || !fb_skip_in))
			burst_on_q <= 1'b1;
	end

	assign gap_en = (st_q == dtfs_pkg::DTFS_RUN) && burst_on_q
		&& !thermal_shutdown_in;
	dtfs_gap_ctrl #(.DT_W(DT_W)) u_gap (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n),
		.enable_in   (gap_en),
		.fixed_in    (gap_option_in == `DTFS_OPT_FIXED),
		.dt_max_in   (DT_W'(`DTFS_DT_MAX_CYC)),
		.on_done_in  (phase_done),
		.tr_hl_in    (tr_upper_to_lower_in),
		.tr_lh_in    (tr_lower_to_upper_in),
		.upper_q_out (up_w),
		.lower_q_out (lo_w),
		.expiry_out  (expiry)
	);

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			drv_upper_out <= 1'b0;
			drv_lower_out <= 1'b0;
		end else begin
			// gated by next state so thermal trip kills drive at once
			drv_upper_out <= up_w && st_d == dtfs_pkg::DTFS_RUN;
			drv_lower_out <= lo_w && st_d == dtfs_pkg::DTFS_RUN;
		end
	end
	logic idle_gap;
	assign idle_gap = st_d == dtfs_pkg::DTFS_RUN && !burst_on_q
		&& mode_q == dtfs_pkg::DTFS_MODE_SKIP;
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bias_fb_out                    <= 1'b0;
			bias_bo_out                    <= 1'b0;
			bias_prot_out                  <= 1'b0;
			front_stage_control_output_out <= 1'b0;
			startup_source_out             <= 1'b1;
			self_supply_mode_out           <= 1'b0;
			soft_start_req_out             <= 1'b0;
			latched_out                    <= 1'b0;
			thermal_stored_out             <= 1'b0;
		end else begin
			bias_fb_out <= st_d != dtfs_pkg::DTFS_OFF
				|| st_q != dtfs_pkg::DTFS_OFF;
			bias_bo_out <= (st_d == dtfs_pkg::DTFS_BLANK
				|| st_d == dtfs_pkg::DTFS_WAIT
				|| st_d == dtfs_pkg::DTFS_RUN) && !idle_gap;
			bias_prot_out <= (st_d == dtfs_pkg::DTFS_BLANK
				|| st_d == dtfs_pkg::DTFS_RUN) && !idle_gap;
			front_stage_control_output_out <= (st_d == dtfs_pkg::DTFS_BLANK
				|| st_d == dtfs_pkg::DTFS_WAIT
				|| st_d == dtfs_pkg::DTFS_RUN) && !idle_gap;
			startup_source_out <= st_d == dtfs_pkg::DTFS_OFF;
			self_supply_mode_out <= st_d == dtfs_pkg::DTFS_WAIT
				|| st_d == dtfs_pkg::DTFS_AREC
				|| st_d == dtfs_pkg::DTFS_THERM
				|| st_d == dtfs_pkg::DTFS_LATCH;
			soft_start_req_out <= st_q == dtfs_pkg::DTFS_BLANK
				&& st_d == dtfs_pkg::DTFS_RUN;
			latched_out <= st_d == dtfs_pkg::DTFS_LATCH;
			thermal_stored_out <= therm_q;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n)
			load_mode_out <= 2'h0;
		else
			load_mode_out <= mode_q;
	end

	// ****************************************
	// checks
	// ****************************************
	no_overlap_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) !(drv_upper_out && drv_lower_out))
		else $error("both switches on");
	latch_hold_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_LATCH
		&& !supply_clear_threshold_in |=> st_q == dtfs_pkg::DTFS_LATCH)
		else $error("latch left early");
	latch_drv_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_LATCH
		|=> !drv_upper_out && !drv_lower_out)
		else $error("drive in latch");
	blank_ign_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_BLANK && !blank_done
		&& !supply_clear_threshold_in |=> st_q == dtfs_pkg::DTFS_BLANK)
		else $error("fault acted in blank");
	therm_stop_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_RUN
		&& thermal_shutdown_in |=> !drv_upper_out && !drv_lower_out)
		else $error("no thermal stop");
	bo_loss_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_RUN
		&& !bulk_level_good_in && !thermal_shutdown_in
		&& !overvoltage_overtemp_input_in && !supply_clear_threshold_in
		|=> front_stage_control_output_out && !bias_prot_out)
		else $error("front stage dropped");
	ovp_latch_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) st_q == dtfs_pkg::DTFS_RUN
		&& overvoltage_overtemp_input_in && !thermal_shutdown_in
		&& !supply_clear_threshold_in
		|=> st_q == dtfs_pkg::DTFS_LATCH && latched_out)
		else $error("no latch on protection");
	fixed_nf_a: assert property (@(posedge clk_in)
		disable iff (!rst_n) gap_option_in == `DTFS_OPT_FIXED |=> !expiry)
		else $error("fault in fixed option");
endmodule : dtfs_sequencer

// ---- verif/dtfs_bridge_model.sv ----
`timescale 1ns/1ps
// ********************************
// bridge node and transition sensor
// ********************************
module dtfs_bridge_model (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       drv_upper_in,
	input  wire logic       drv_lower_in,
	input  wire logic       silent_in,
	input  wire logic [7:0] delay_in,
	output logic            tr_hl_out,
	output logic            tr_lh_out
);
	logic       last_q;
	logic [7:0] cnt_q;
	// flag only once both switches rest for delay_in cycles
	// stale flags drop late, so a long idle gap gets no free flag
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			last_q    <= 1'b0;
			cnt_q     <= 8'h00;
			tr_hl_out <= 1'b0;
			tr_lh_out <= 1'b0;
		end else if (drv_upper_in || drv_lower_in) begin
			last_q    <= drv_upper_in;
			cnt_q     <= 8'h00;
			tr_hl_out <= 1'b0;
			tr_lh_out <= 1'b0;
		end else begin
			if (cnt_q != 8'hff) begin
				cnt_q <= cnt_q + 8'h01;
			end
			if (cnt_q == delay_in && !silent_in) begin
				tr_hl_out <= last_q;
				tr_lh_out <= !last_q;
			end
			if (cnt_q == 8'hfe) begin
				tr_hl_out <= 1'b0;
				tr_lh_out <= 1'b0;
			end
		end
	end
endmodule : dtfs_bridge_model

// ---- verif/dtfs_sequencer_bench.sv ----
`timescale 1ns/1ps
module dtfs_sequencer_bench;
	logic        clk, arst_n, son, sclr, bulk, therm, ovp;
	logic        fbl, fbs, cen, silent, thl, tlh;
	logic [1:0]  opt, lm;
	logic [7:0]  lim, dly, obs;
	logic [11:0] ton;
	logic        du, dl, sus, ssm, bbo, bfb, bpr, fsc, ssr, lat, ths;
	int          n_fail, check_count, n, wu, g, wl;
	localparam int DU = 0, DL = 1, SUS = 2, LAT = 6, BPR = 4, SSR = 5;
	assign obs = {ths, lat, ssr, bpr, ssm, sus, dl, du};
	// ********************************
	// design and bridge
	// ********************************
	dtfs_sequencer #(.AREC_CYC(100), .BLANK_CYC(40), .SKIP_CYC(50)) dut (
		.clk_in(clk), .arst_n_in(arst_n),
		.supply_on_threshold_in(son), .supply_clear_threshold_in(sclr),
		.bulk_level_good_in(bulk), .thermal_shutdown_in(therm),
		.overvoltage_overtemp_input_in(ovp),
		.fb_light_in(fbl), .fb_skip_in(fbs), .gap_option_in(opt),
		.gap_count_en_in(cen), .gap_fault_count_limit_in(lim),
		.on_time_in(ton), .light_off_time_in(ton),
		.tr_upper_to_lower_in(thl), .tr_lower_to_upper_in(tlh),
		.drv_upper_out(du), .drv_lower_out(dl),
		.startup_source_out(sus), .self_supply_mode_out(ssm),
		.bias_bo_out(bbo), .bias_fb_out(bfb), .bias_prot_out(bpr),
		.front_stage_control_output_out(fsc), .soft_start_req_out(ssr),
		.latched_out(lat), .thermal_stored_out(ths), .load_mode_out(lm));
	dtfs_bridge_model bridge (.clk_in(clk), .rst_n_in(arst_n),
		.drv_upper_in(du), .drv_lower_in(dl), .silent_in(silent),
		.delay_in(dly), .tr_hl_out(thl), .tr_lh_out(tlh));
	// ********************************
	// helpers
	// ********************************
	task tick(input int k = 1);
		repeat (k) begin
			@(posedge clk);
			#1;
		end
	endtask : tick
	task chk(input logic got, input logic exp, input string m);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task chk_in(input int v, input int lo, input int hi, input string m);
		chk(v >= lo && v <= hi, 1'b1, m);
	endtask : chk_in
	task wt(input int b, input logic v, input int k, output int c);
		c = 0;
		while (obs[b] !== v && c < k) begin
			tick();
			c++;
		end
	endtask : wt
	task meas();
		wt(DU, 1'b1, 400, n);
		for (wu = 0; du === 1'b1 && wu < 400; wu++) tick();
		for (g = 0; dl !== 1'b1 && g < 400; g++) tick();
		for (wl = 0; dl === 1'b1 && wl < 400; wl++) tick();
	endtask : meas
	task start_run();
		son = 1'b0;
		tick();
		son = 1'b1;
		tick(3);
		chk(bbo & bfb & fsc, 1'b1, "blocks not biased");
		wt(SSR, 1'b1, 60, n);
		chk(ssr, 1'b1, "no soft start");
	endtask : start_run
	// supply drop clears any state, then a fresh start
	task restart(input logic [1:0] o, input logic s);
		opt = o;
		silent = s;
		sclr = 1'b1;
		tick(2);
		sclr = 1'b0;
		start_run();
	endtask : restart
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// never both switches on
	always @(negedge clk) if (arst_n) chk(du & dl, 1'b0, "overlap");
	initial begin
		#400000;
		n_fail++;
		$display("MISMATCH %0t watchdog", $time);
		wrap_up();
	end
	initial begin
		{son, sclr, therm, ovp, fbl, fbs, cen, silent, arst_n} = '0;
		{bulk, opt, lim, dly, ton} = {1'b1, 2'h0, 8'h03, 8'h03, 12'h014};
		repeat (8) @(posedge clk);
		#1 arst_n = 1'b1;
		tick(3);
		chk(sus & ~du & ~dl & ~lat, 1'b1, "reset values");
		// blank hides the fault, then a bulk wait
		bulk = 1'b0;
		son = 1'b1;
		tick(3);
		ovp = 1'b1;
		tick(10);
		ovp = 1'b0;
		tick(40);
		chk(lat, 1'b0, "fault seen in blank");
		chk(~du & ~dl & ssm & bfb, 1'b1, "wait state");
		bulk = 1'b1;
		tick(3);
		chk(sus, 1'b1, "no startup source");
		start_run();
		meas();
		chk_in(wu, 21, 21, "upper width");
		chk_in(wl, 21, 21, "lower width");
		chk_in(g, 4, 20, "gap with flag");
		restart(2'h3, 1'b0);
		meas();
		chk_in(g, 120, 130, "fixed gap");
		chk(lat, 1'b0, "fixed latched");
		restart(2'h0, 1'b1);
		meas();
		chk_in(g, 120, 130, "forced gap");
		chk(lat, 1'b0, "no fault latched");
		meas();
		chk_in(wu, 21, 21, "switching stopped");
		// latching option, then recoveries ignored
		restart(2'h1, 1'b1);
		wt(LAT, 1'b1, 400, n);
		chk(lat, 1'b1, "no latch on expiry");
		bulk = 1'b0;
		therm = 1'b1;
		tick(5);
		bulk = 1'b1;
		therm = 1'b0;
		son = 1'b0;
		tick();
		son = 1'b1;
		tick(80);
		chk(lat & ~du & ~dl, 1'b1, "left latch");
		sclr = 1'b1;
		tick(3);
		chk(lat, 1'b0, "latch not cleared");
		// counter option, limit three
		cen = 1'b1;
		restart(2'h1, 1'b1);
		wt(DU, 1'b1, 300, n);
		wt(DL, 1'b1, 300, n);
		chk(lat, 1'b0, "latched before limit");
		wt(LAT, 1'b1, 600, n);
		chk(lat, 1'b1, "no latch at limit");
		cen = 1'b0;
		// auto recovery waits its delay
		restart(2'h2, 1'b1);
		wt(SUS, 1'b1, 400, n);
		chk_in(n, 215, 245, "recovery delay");
		chk(du | dl | lat, 1'b0, "recovery stop");
		silent = 1'b0;
		start_run();
		// thermal stop and full restart
		restart(2'h0, 1'b0);
		tick(30);
		therm = 1'b1;
		tick(2);
		chk(~du & ~dl & ths, 1'b1, "thermal stop");
		tick(20);
		therm = 1'b0;
		tick(3);
		chk(sus, 1'b1, "thermal restart");
		start_run();
		tick(30);
		bulk = 1'b0;
		tick(3);
		chk(~du & ~dl & ~bpr & fsc, 1'b1, "bulk loss");
		bulk = 1'b1;
		tick(3);
		start_run();
		ovp = 1'b1;
		tick(3);
		chk(lat & bfb & ~bpr & ssm, 1'b1, "protection latch");
		ovp = 1'b0;
		restart(2'h0, 1'b0);
		fbl = 1'b1;
		tick(3);
		chk(lm === 2'h1, 1'b1, "light mode");
		fbs = 1'b1;
		tick(3);
		chk(lm === 2'h2, 1'b1, "skip mode");
		wt(BPR, 1'b0, 300, n);
		chk(~bpr & bfb, 1'b1, "skip idle bias");
		// idle gap stretches while feedback stays below skip level
		tick(60);
		chk(du | dl, 1'b0, "burst at no load");
		fbs = 1'b0;
		wt(DU, 1'b1, 200, n);
		chk(du, 1'b1, "no burst after skip out");
		{fbl, fbs} = 2'b00;
		tick(3);
		chk(lm === 2'h0, 1'b1, "symmetric mode");
		wrap_up();
	end
endmodule : dtfs_sequencer_bench
